// ---- verilog/dfs_pkg.sv ----
// Purpose: shared constants and carriers for the sample sequencer
// Assumes: 40 MHz core clock, one register port with byte enables
// Notes: offsets are byte addresses on the local register port
package dfs_pkg;

	// clocking and timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned REF_HZ = 8000000;
	localparam logic [2:0] REF_DIV = 3'(CLK_HZ / REF_HZ);

	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_TIMER = 8'h24;
	localparam logic [7:0] OFS_START = 8'h28;
	localparam logic [7:0] OFS_FIFO = 8'h2c;

	// control/status field positions
	localparam int MODE_LSB = 0;
	localparam int TRIG_LSB = 2;
	localparam int IE_BIT = 4;
	localparam int PRST_BIT = 5;
	localparam int IRQ_BIT = 12;
	localparam int NEMPTY_BIT = 13;
	localparam int BELOW_BIT = 14;
	localparam int FULL_BIT = 15;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] TIMER_RST = 16'h0000;

	// sample word layout
	localparam int EOS_BIT = 19;
	localparam int TAG_MSB = 18;
	localparam int TAG_LSB = 16;
	localparam int WORD_W = 20;
	localparam int SMP_W = 16;
	localparam int NCH = 8;

	// sample store
	localparam int AW = 10;
	localparam logic [10:0] FIFO_DEPTH = 11'h400;

	// trigger direction codes
	localparam logic [1:0] TRIG_IN = 2'b01;
	localparam logic [1:0] TRIG_OUT = 2'b10;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_CONT = 2'b10,
		MODE_RECYCLE = 2'b11
	} dfs_mode_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ARMED = 2'b01,
		SEQ_POP = 2'b10
	} dfs_seq_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} dfs_req_t;

	typedef struct packed {
		dfs_mode_t mode;
		logic [1:0] trig;
		logic ie;
		logic prst;
		logic [15:0] timer;
		logic [2:0] div;
		logic [15:0] tmr;
		dfs_seq_t seq;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [10:0] count;
		logic [NCH-1:0][SMP_W-1:0] dac;
		logic [NCH-1:0] upd;
		logic [2:0] sync;
		logic trig_lvl;
		logic trig_o_n;
		logic trig_oe;
		logic claim_in;
		logic claim_out;
		logic irq;
		logic [31:0] rdata;
		logic rvalid;
	} dfs_state_t;

endpackage

// ---- verilog/dfs_sequencer.sv ----
// Purpose: moves tagged samples from the sample store to eight outputs
// Assumes: one core clock; trigger pin is asynchronous to it
// Notes: store holds 1024 words of 20 bits, read combinationally
//
// How it works
// RL1: recycle replays from first entry written after reset to last, looping.
// RL2: software must not push samples while recycle playback runs.
// RL3: software loads the whole waveform before starting recycle playback.
// RL4: sample bits 18:16 name the output channel receiving the value.
// RL5: a cycle pops samples to their channels, ending after an eos word.
// RL6: channels not written in a cycle hold their last value.
// RL7: recycle cycles start on timer expiry or each external trigger. Triggers that arrive while a cycle is popping are ignored.
// RL8: mode 11 selects recycle; start by software or external trigger.
// RL9: reset clears every control bit of the control/status register.
// RL10: control/status accepts byte, halfword and word accesses.
// RL11: mode 00 off, 01 single conversion, 10 continuous new data.
// RL12: single mode needs one start per cycle; up to eight channels.
// RL13: continuous mode, once started, runs cycles at the timer rate.
// RL14: empty store in continuous mode leaves outputs unchanged.
// RL15: trigger field 01 input active low, 10 output, else off.
// RL16: exactly one module drives the trigger; the others receive it.
// RL17: trigger enters on digital channel 1, leaves on channel 9.
// RL18: with trigger as input, software sets digital channels 0-7 input.
// RL19: software selects recycle, sets pointer reset, loads, then starts.
// RL20: with interrupt enable set, request while below the threshold.
// RL21: timer register divides an 8 MHz reference into trigger periods.
// RL22: trigger input is synchronised; each low-going edge is one event.
`timescale 1ns/1ps
module dfs_sequencer (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port
	input wire dfs_pkg::dfs_req_t reg_req,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// threshold from the threshold register
	input wire logic [10:0] fifo_threshold,
	// external trigger pins
	input wire logic dio_ch1_in,
	output logic dio_ch9_out,
	output logic dio_ch9_oe,
	output logic dio_ch1_claim,
	output logic dio_ch9_claim,
	// converter side and interrupt request
	output logic [7:0][15:0] dac_value,
	output logic [7:0] dac_update,
	output logic irq_req
);

	////////////////////////////////////////////////////////////////////
	// state and sample store

	dfs_pkg::dfs_state_t q;
	dfs_pkg::dfs_state_t d;
	logic [dfs_pkg::WORD_W-1:0] mem [0:1023];
	logic fifo_wr;
	logic ptr_reset;
	logic [dfs_pkg::WORD_W-1:0] head;

	assign head = mem[q.rd_ptr];
	assign ptr_reset = reg_req.wr && reg_req.addr == dfs_pkg::OFS_CTRL &&
		reg_req.be[0] && reg_req.wdata[dfs_pkg::PRST_BIT];
	// full store drops the word; software sees the full flag
	assign fifo_wr = reg_req.wr && reg_req.addr == dfs_pkg::OFS_FIFO &&
		(|reg_req.be) && q.count != dfs_pkg::FIFO_DEPTH && !ptr_reset;

	always_ff @(posedge core_clk) begin
		if (fifo_wr) begin
			mem[q.wr_ptr] <= reg_req.wdata[dfs_pkg::WORD_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic ext_ev;
		logic sw_start;
		logic start_ev;
		logic tick8;
		logic tmr_ev;
		logic cycle_go;
		logic popped;
		logic recycle;
		logic [2:0] tag;
		logic [dfs_pkg::AW-1:0] rd_next;
		ext_ev = 1'b0;
		sw_start = 1'b0;
		start_ev = 1'b0;
		tick8 = 1'b0;
		tmr_ev = 1'b0;
		cycle_go = 1'b0;
		popped = 1'b0;
		recycle = 1'b0;
		tag = 3'h0;
		rd_next = '0;

		d = q;
		d.upd = '0;
		d.rvalid = 1'b0;
		d.trig_o_n = 1'b1;

		// trigger input: three flops, change taken when last two agree
		d.sync = {q.sync[1:0], dio_ch1_in}; // RL22
		if (q.sync[2] == q.sync[1] && q.sync[2] != q.trig_lvl) begin
			d.trig_lvl = q.sync[2];
			ext_ev = q.trig == dfs_pkg::TRIG_IN && !q.sync[2]; // RL15 RL22
		end

		sw_start = reg_req.wr && reg_req.addr == dfs_pkg::OFS_START &&
			(|reg_req.be);
		start_ev = sw_start || ext_ev; // RL8

		// 8 MHz reference enable
		tick8 = q.div == dfs_pkg::REF_DIV - 3'h1;
		d.div = tick8 ? 3'h0 : q.div + 3'h1;

		// periodic trigger: period is timer value reference ticks
		if (q.seq == dfs_pkg::SEQ_IDLE || q.timer == 16'h0000) begin
			d.tmr = 16'h0000;
		end else if (tick8) begin
			if (q.tmr >= q.timer - 16'h0001) begin // RL21
				d.tmr = 16'h0000;
				tmr_ev = 1'b1;
			end else begin
				d.tmr = q.tmr + 16'h0001;
			end
		end

		recycle = q.mode == dfs_pkg::MODE_RECYCLE;
		// recycle also answers the external trigger between cycles
		cycle_go = tmr_ev || (recycle && ext_ev); // RL7 RL13

		// sequencer
		unique case (q.seq)
			dfs_pkg::SEQ_IDLE: begin
				if (start_ev && q.mode != dfs_pkg::MODE_OFF) begin
					d.seq = dfs_pkg::SEQ_POP; // RL11 RL12
				end
			end
			dfs_pkg::SEQ_ARMED: begin
				if (cycle_go) begin
					d.seq = dfs_pkg::SEQ_POP;
				end
			end
			dfs_pkg::SEQ_POP: begin
				// in recycle mode count is what was written, never popped
				if (q.count == 11'h000) begin
					// nothing left: outputs keep their values
					d.seq = q.mode == dfs_pkg::MODE_SINGLE ?
						dfs_pkg::SEQ_IDLE : dfs_pkg::SEQ_ARMED; // RL14
				end else begin
					tag = head[dfs_pkg::TAG_MSB:dfs_pkg::TAG_LSB]; // RL4
					d.dac[tag] = head[dfs_pkg::SMP_W-1:0]; // RL5 RL6
					d.upd[tag] = 1'b1;
					rd_next = q.rd_ptr + 10'h001;
					if (recycle) begin
						// wrap after the last word written
						d.rd_ptr = rd_next == q.wr_ptr ? '0 : rd_next; // RL1
					end else begin
						d.rd_ptr = rd_next;
						popped = 1'b1;
					end
					if (head[dfs_pkg::EOS_BIT]) begin
						d.seq = q.mode == dfs_pkg::MODE_SINGLE ?
							dfs_pkg::SEQ_IDLE : dfs_pkg::SEQ_ARMED; // RL5 RL12
					end
				end
			end
			default: begin
				d.seq = dfs_pkg::SEQ_IDLE;
			end
		endcase
		if (q.mode == dfs_pkg::MODE_OFF) begin
			d.seq = dfs_pkg::SEQ_IDLE; // RL11
		end

		// trigger out: one low pulse per started output cycle
		if (q.trig == dfs_pkg::TRIG_OUT && d.seq == dfs_pkg::SEQ_POP &&
			q.seq != dfs_pkg::SEQ_POP) begin
			d.trig_o_n = 1'b0; // RL15
		end
		d.trig_oe = q.trig == dfs_pkg::TRIG_OUT; // RL17
		d.claim_in = q.trig == dfs_pkg::TRIG_IN; // RL17
		d.claim_out = q.trig == dfs_pkg::TRIG_OUT; // RL17

		// store pointers and fill level
		if (fifo_wr) begin
			d.wr_ptr = q.wr_ptr + 10'h001;
		end
		d.count = q.count + {10'h000, fifo_wr} - {10'h000, popped};

		// register writes, each byte lane on its own
		if (reg_req.wr && reg_req.addr == dfs_pkg::OFS_CTRL &&
			reg_req.be[0]) begin // RL10
			d.mode = dfs_pkg::dfs_mode_t'(reg_req.wdata[1:0]); // RL8 RL11
			d.trig = reg_req.wdata[dfs_pkg::TRIG_LSB +: 2]; // RL15
			d.ie = reg_req.wdata[dfs_pkg::IE_BIT]; // RL20
			d.prst = reg_req.wdata[dfs_pkg::PRST_BIT];
		end
		if (ptr_reset) begin
			// restart recycle from the first word written next
			d.wr_ptr = '0; // RL1
			d.rd_ptr = '0;
			d.count = 11'h000;
		end
		if (reg_req.wr && reg_req.addr == dfs_pkg::OFS_TIMER) begin
			if (reg_req.be[0]) begin
				d.timer[7:0] = reg_req.wdata[7:0];
			end
			if (reg_req.be[1]) begin
				d.timer[15:8] = reg_req.wdata[15:8];
			end
		end

		// level request, no latch: follows the fill level
		d.irq = q.ie && q.count < fifo_threshold; // RL20

		// register reads; upper lanes of narrow registers read zero
		if (reg_req.rd) begin
			d.rvalid = 1'b1;
			d.rdata = 32'h0000_0000;
			if (reg_req.addr == dfs_pkg::OFS_CTRL) begin // RL10
				d.rdata[5:0] = {q.prst, q.ie, q.trig, q.mode};
				d.rdata[dfs_pkg::IRQ_BIT] = q.irq;
				d.rdata[dfs_pkg::NEMPTY_BIT] = q.count != 11'h000;
				d.rdata[dfs_pkg::BELOW_BIT] = q.count < fifo_threshold;
				d.rdata[dfs_pkg::FULL_BIT] = q.count == dfs_pkg::FIFO_DEPTH;
			end else if (reg_req.addr == dfs_pkg::OFS_TIMER) begin
				d.rdata[15:0] = q.timer;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0; // RL9
			q.mode <= dfs_pkg::MODE_OFF;
			q.seq <= dfs_pkg::SEQ_IDLE;
			q.sync <= 3'h7;
			q.trig_lvl <= 1'b1;
			q.trig_o_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign reg_rdata = q.rdata;
	assign reg_rvalid = q.rvalid;
	assign dio_ch9_out = q.trig_o_n;
	assign dio_ch9_oe = q.trig_oe;
	assign dio_ch1_claim = q.claim_in;
	assign dio_ch9_claim = q.claim_out;
	assign dac_value = q.dac;
	assign dac_update = q.upd;
	assign irq_req = q.irq;

endmodule

// ---- verif/dfs_sequencer_asserts.sv ----
// Purpose: port checks for the sample sequencer
// Assumes: one clock, reset active low
// Notes: bound from the bench top
`timescale 1ns/1ps
module dfs_sequencer_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port and threshold
	input wire dfs_pkg::dfs_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [10:0] fifo_threshold,
	// pins and outputs
	input wire logic dio_ch9_out,
	input wire logic dio_ch9_oe,
	input wire logic dio_ch1_claim,
	input wire logic dio_ch9_claim,
	input wire logic [7:0][15:0] dac_value,
	input wire logic [7:0] dac_update,
	input wire logic irq_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_rd; reg_req.rd |=> reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read unanswered");
	property p_rdh; !reg_rvalid |-> $stable(reg_rdata); endproperty
	a_rdh: assert property (p_rdh) else $error("rdata moved");
	property p_hold; dac_update == 8'h00 |-> $stable(dac_value); endproperty
	a_hold: assert property (p_hold) else $error("dac drift");
	property p_one; $onehot0(dac_update); endproperty
	a_one: assert property (p_one) else $error("two updates");
	property p_oe; dio_ch9_oe == dio_ch9_claim; endproperty
	a_oe: assert property (p_oe) else $error("oe mismatch");
	property p_cl; !(dio_ch1_claim && dio_ch9_claim); endproperty
	a_cl: assert property (p_cl) else $error("both claimed");
	property p_tp; !dio_ch9_out |=> dio_ch9_out; endproperty
	a_tp: assert property (p_tp) else $error("long pulse");
	property p_to; !dio_ch9_out |-> dio_ch9_oe; endproperty
	a_to: assert property (p_to) else $error("pulse undriven");
	property p_irq; (fifo_threshold == 11'h000) [*2] |-> !irq_req; endproperty
	a_irq: assert property (p_irq) else $error("irq at zero");
endmodule

// ---- verif/dfs_dac_model.sv ----
// Purpose: eight converters latching on their update strobes
// Assumes: same clock as the sequencer
// Notes: level is what each analog output would show
`timescale 1ns/1ps
module dfs_dac_model (
	// converter side
	input wire logic core_clk,
	input wire logic [7:0] dac_update,
	input wire logic [7:0][15:0] dac_value,
	// held levels
	output logic [7:0][15:0] level
);
	initial level = '0;
	always @(posedge core_clk)
		for (int n = 0; n < 8; n++)
			if (dac_update[n]) level[n] <= dac_value[n];
endmodule

// ---- verif/dfs_sequencer_test.sv ----
// Purpose: self-checking bench for the sample sequencer
// Assumes: inputs move 1 ns after each rising edge
// Notes: rows hold {word, channel, value}
`timescale 1ns/1ps
module dfs_sequencer_test;
	logic core_clk, rst_b, trig_n, rvalid, ch9, oe, cl1, cl9, irq;
	dfs_pkg::dfs_req_t req;
	logic [10:0] thr;
	logic [31:0] rdata, r;
	logic [7:0][15:0] val, lvl, exp_v;
	logic [7:0] upd_s;
	int err_total, n_compared, i;
	logic [38:0] rows [8] = '{{20'h8ffff, 3'h0, 16'hffff},
		{20'h98000, 3'h1, 16'h8000}, {20'ha7fff, 3'h2, 16'h7fff},
		{20'hb0001, 3'h3, 16'h0001}, {20'hc1234, 3'h4, 16'h1234},
		{20'hdabcd, 3'h5, 16'habcd}, {20'he5a5a, 3'h6, 16'h5a5a},
		{20'hfa5a5, 3'h7, 16'ha5a5}};
	dfs_sequencer dut (.core_clk, .rst_b, .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .fifo_threshold(thr), .dio_ch1_in(trig_n),
		.dio_ch9_out(ch9), .dio_ch9_oe(oe), .dio_ch1_claim(cl1),
		.dio_ch9_claim(cl9), .dac_value(val), .dac_update(upd_s),
		.irq_req(irq));
	dfs_dac_model conv (.core_clk, .dac_update(upd_s), .dac_value(val),
		.level(lvl));
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge core_clk) #1;
		req.wr = 1;
		req.addr = a;
		req.be = b;
		req.wdata = d;
		@(posedge core_clk) #1;
		req.wr = 0;
	endtask
	task automatic ctl(input logic [7:0] c);
		wr(8'h20, 4'h1, {24'h0, c});
	endtask
	task automatic push(input logic [19:0] w);
		wr(8'h2c, 4'hf, {12'h0, w});
	endtask
	task automatic go();
		wr(8'h28, 4'hf, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		@(posedge core_clk) #1;
		req.rd = 1;
		req.addr = a;
		@(posedge core_clk) #1;
		req.rd = 0;
		for (k = 0; k < 3 && rvalid !== 1'b1; k++) @(posedge core_clk) #1;
		if (k == 3) begin
			err_total++;
			close_out();
		end
		r = rdata;
	endtask
	task automatic upd(input logic [2:0] c, input logic [15:0] v);
		int k;
		for (k = 0; k < 200 && upd_s === 8'h00; k++) @(posedge core_clk) #1;
		chk(upd_s, 8'h01 << c);
		chk(val[c], v);
		exp_v[c] = v;
		if (k == 200) close_out();
		@(posedge core_clk) #1;
	endtask
	task automatic quiet(input int n);
		logic [7:0] o = 8'h00;
		repeat (n) begin
			@(posedge core_clk) #1;
			o |= upd_s;
		end
		chk(o, 32'h0);
	endtask
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		core_clk = 0; rst_b = 0; req = '0; thr = '0; trig_n = 1;
		exp_v = '0; err_total = 0; n_compared = 0;
		repeat (16) @(posedge core_clk);
		#1 rst_b = 1;
		rd(8'h20);
		chk(r, 32'h0);
		chk(ch9, 32'h1);
		$display("end reset");
		ctl(8'h0d);
		wr(8'h20, 4'h2, 32'hff00);
		rd(8'h20);
		chk(r & 32'h3f, 32'h0d);
		for (i = 0; i < 4; i++) begin
			wr(8'h20, 4'h3, i);
			rd(8'h20);
			chk(r & 32'h3f, i);
		end
		$display("end regs");
		ctl(8'h01);
		for (i = 0; i < 8; i++) begin
			push(rows[i][38:19]);
			go();
			upd(rows[i][18:16], rows[i][15:0]);
		end
		$display("end rows");
		push(20'h21111); push(20'hd2222); push(20'hf3333);
		go();
		upd(2, 16'h1111);
		upd(5, 16'h2222);
		quiet(10);
		go();
		upd(7, 16'h3333);
		$display("end multi");
		wr(8'h24, 4'h3, 32'h2);
		push(20'h80001); push(20'h80002);
		ctl(8'h02);
		go();
		upd(0, 16'h0001);
		upd(0, 16'h0002);
		quiet(40);
		$display("end cont");
		ctl(8'h00); ctl(8'h23);
		push(20'h8aaaa); push(20'h9bbbb);
		go();
		upd(0, 16'haaaa);
		upd(1, 16'hbbbb);
		upd(0, 16'haaaa);
		ctl(8'h20);
		$display("end recycle");
		ctl(8'h05);
		@(posedge core_clk) #1;
		chk(cl1, 32'h1);
		push(20'h8c0de); push(20'h9beef);
		trig_n = 0;
		upd(0, 16'hc0de);
		quiet(10);
		trig_n = 1;
		ctl(8'h0d);
		trig_n = 0;
		quiet(20);
		trig_n = 1;
		go();
		upd(1, 16'hbeef);
		ctl(8'h09);
		@(posedge core_clk) #1;
		chk(oe, 32'h1);
		chk(cl9, 32'h1);
		push(20'h85555);
		go();
		for (i = 0; i < 20 && ch9 !== 1'b0; i++) @(posedge core_clk) #1;
		chk(ch9, 32'h0);
		upd(0, 16'h5555);
		$display("end trig");
		thr = 11'h002;
		ctl(8'h11);
		rd(8'h20);
		chk(irq, 32'h1);
		push(20'hb0007); push(20'hb0008);
		rd(8'h20);
		chk(irq, 32'h0);
		$display("end irq");
		for (i = 0; i < 8; i++) chk(lvl[i], exp_v[i]);
		close_out();
	end
endmodule
bind dfs_sequencer dfs_sequencer_asserts chk_i (.core_clk, .rst_b, .reg_req,
	.reg_rdata, .reg_rvalid, .fifo_threshold, .dio_ch9_out, .dio_ch9_oe,
	.dio_ch1_claim, .dio_ch9_claim, .dac_value, .dac_update, .irq_req);
